// ==== common/tfd_pkg.sv ====
// Constants and types shared by the tag frame decoder and its bit front end.
// Assumes a 25 MHz core clock and a 125 kHz reader carrier.
package tfd_pkg;

	// ----------------------------------------
	// Clocks and bit timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ          = 25_000_000;
	localparam int unsigned CARRIER_HZ      = 125_000;
	localparam int unsigned CARRIER_PER_BIT = 64;
	localparam int unsigned BIT_CYC         = CLK_HZ / CARRIER_HZ * CARRIER_PER_BIT;

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int unsigned SYNC_ONES   = 9;
	localparam int unsigned ROWS        = 10;
	localparam int unsigned NIB_BITS    = 4;
	localparam int unsigned ROW_BITS    = NIB_BITS + 1;
	localparam int unsigned COL_BITS    = 4;
	localparam int unsigned BODY_BITS   = ROWS * ROW_BITS + COL_BITS + 1;
	localparam int unsigned ID_BITS     = ROWS * NIB_BITS;
	localparam int unsigned VENDOR_BITS = 8;
	localparam int unsigned BYTE_BITS   = 8;
	localparam int unsigned ID_BYTES    = ID_BITS / BYTE_BITS;
	localparam logic        STOP_VAL    = 1'b0;

	// ----------------------------------------
	// Shutdown and restart
	// ----------------------------------------
	localparam int unsigned SHUTDOWN_MS  = 10;
	localparam int unsigned RESTART_MS   = 100;
	localparam int unsigned SHUTDOWN_CYC = CLK_HZ / 1000 * SHUTDOWN_MS;
	localparam int unsigned RESTART_CYC  = CLK_HZ / 1000 * RESTART_MS;
	localparam int unsigned SENSE_CYC    = 16;

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	localparam int unsigned BAUD           = 9600;
	localparam int unsigned BAUD_CYC       = CLK_HZ / BAUD;
	localparam int unsigned UART_LAST_BIT  = 9;
	localparam logic        UART_IDLE      = 1'b1;
	localparam logic        UART_START     = 1'b0;
	localparam int unsigned PULSE_US       = 50;
	localparam int unsigned PULSE_GAP_US   = 1000;
	localparam int unsigned PULSE_CYC      = CLK_HZ / 1_000_000 * PULSE_US;
	localparam int unsigned PULSE_GAP_CYC  = CLK_HZ / 1_000_000 * PULSE_GAP_US;
	localparam int unsigned CNT_W          = 24;

	typedef enum logic [4:0] {
		ST_WAKE    = 5'h01,
		ST_HUNT    = 5'h02,
		ST_COLLECT = 5'h04,
		ST_SHUT    = 5'h08,
		ST_DOWN    = 5'h10
	} tfd_state_e;

endpackage

// ==== common/tfd_bit_if.sv ====
// Recovered bit stream between the Manchester front end and the frame decoder.
// Both ends sit on the core clock.
interface tfd_bit_if;
	logic bit_valid;
	logic bit_value;
	logic restart;

	modport rx  (input restart, output bit_valid, output bit_value);
	modport dec (output restart, input bit_valid, input bit_value);
endinterface

// ==== design/tfd_manchester_rx.sv ====
// Manchester bit recovery from the demodulated carrier envelope.
// Assumes rx_line_i is asynchronous; restart comes from the core clock domain.
module tfd_manchester_rx
	import tfd_pkg::*;
#(
	parameter int unsigned BIT_CYC_P = BIT_CYC
) (
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic rx_line_i,
	tfd_bit_if.rx     bits
);

	localparam int unsigned W      = $clog2(BIT_CYC_P * 2);
	localparam int unsigned MID_LO = BIT_CYC_P * 3 / 4;
	localparam int unsigned LOST   = BIT_CYC_P * 3 / 2;

	if (BIT_CYC_P < 8) begin : g_bad
		$error("tfd_manchester_rx: bit period too short");
	end

	// ----------------------------------------
	// Input capture
	// ----------------------------------------
	logic [2:0]   sync_r;
	logic         lvl_r;
	logic         locked_r;
	logic [W-1:0] cnt_r;
	logic         valid_r;
	logic         value_r;

	wire agree_w = sync_r[1] == sync_r[2];
	wire edge_w  = agree_w && (sync_r[2] != lvl_r);
	// Edges near a bit boundary fall before three quarters of a bit and are skipped
	wire mid_w   = edge_w && (!locked_r || cnt_r >= W'(MID_LO));
	wire lost_w  = cnt_r >= W'(LOST);

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_r <= 3'h0;
			lvl_r  <= 1'b0;
		end else begin
			sync_r <= {sync_r[1:0], rx_line_i};
			if (edge_w) begin
				lvl_r <= sync_r[2];
			end
		end
	end

	// ----------------------------------------
	// Bit clock recovery
	// ----------------------------------------
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r    <= '0;
			locked_r <= 1'b0;
			valid_r  <= 1'b0;
			value_r  <= 1'b0;
		end else begin
			valid_r <= mid_w && !bits.restart;
			if (mid_w) begin
				value_r <= sync_r[2];
			end
			if (bits.restart || mid_w) begin
				cnt_r <= '0;
			end else if (!lost_w) begin
				cnt_r <= cnt_r + W'(1);
			end
			if (bits.restart || lost_w) begin
				locked_r <= 1'b0;
			end else if (mid_w) begin
				locked_r <= 1'b1;
			end
		end
	end

	assign bits.bit_valid = valid_r;
	assign bits.bit_value = value_r;

endmodule

// ==== design/tfd_frame_decoder.sv ====
// Tag frame decoder: sync hunt, parity checks, identifier out, shutdown control.
// Assumes demodulated envelope on rx_demod_i and external pull-ups on pulse lines.
//
// Notes on behaviour
// - Bits arrive at carrier over sixty-four.
// - Frames are 64 Manchester coded bits.
// - Input is the demodulated amplitude keyed signal.
// - Nine ones start a frame, then collect.
// - Parity bit follows every nibble, ten rows.
// - Row parity set when nibble ones odd.
// - First byte vendor, next four unique identifier.
// - Four column parities then zero stop bit.
// - Column parity covers payload only, not sync.
// - Power-down request active low, pulled up.
// - Shutdown completes within ten milliseconds.
// - Ready again within hundred milliseconds.
// - Release restarts everything from scratch; pull-up sense not redone, id_o and vendor_id_o kept.
// - Serial output 9600 baud, no parity.
// - Zero line zeros only, one line ones.
// - Pulse lines open drain, pulled up outside.
// - Pulse output enabled only if both pulled.
module tfd_frame_decoder
	import tfd_pkg::*;
#(
	parameter int unsigned BIT_CYC_P       = BIT_CYC,
	parameter int unsigned SHUTDOWN_CYC_P  = SHUTDOWN_CYC,
	parameter int unsigned RESTART_CYC_P   = RESTART_CYC,
	parameter int unsigned BAUD_CYC_P      = BAUD_CYC,
	parameter int unsigned PULSE_CYC_P     = PULSE_CYC,
	parameter int unsigned PULSE_GAP_CYC_P = PULSE_GAP_CYC
) (
	input  wire logic                   core_clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   rx_demod_i,
	input  wire logic                   power_down_request_n_i,
	input  wire logic                   zero_pulse_line_i,
	output logic                        zero_pulse_line_o,
	output logic                        zero_pulse_line_oe_o,
	input  wire logic                   one_pulse_line_i,
	output logic                        one_pulse_line_o,
	output logic                        one_pulse_line_oe_o,
	output logic                        uart_tx_o,
	output logic [ID_BITS-1:0]          id_o,
	output logic [VENDOR_BITS-1:0]      vendor_id_o,
	output logic                        id_valid_o,
	output logic                        frame_error_o,
	output logic                        ready_o,
	output logic                        powered_down_o,
	output logic                        pulse_out_enabled_o
);

	localparam int unsigned MAXC = 2 ** CNT_W;

	if (SHUTDOWN_CYC_P < 1 || SHUTDOWN_CYC_P >= MAXC || RESTART_CYC_P < 1 || RESTART_CYC_P >= MAXC ||
		BAUD_CYC_P < 2 || BAUD_CYC_P >= MAXC || PULSE_CYC_P < 1 || PULSE_CYC_P >= MAXC ||
		PULSE_GAP_CYC_P < 1 || PULSE_GAP_CYC_P >= MAXC) begin : g_bad
		$error("tfd_frame_decoder: count parameter out of range");
	end

	// ----------------------------------------
	// Bit front end
	// ----------------------------------------
	tfd_bit_if bits ();

	tfd_manchester_rx #(
		.BIT_CYC_P (BIT_CYC_P)
	) u_rx (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.rx_line_i  (rx_demod_i),
		.bits       (bits.rx)
	);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Index 0 power-down request, 1 zero line, 2 one line
	wire  [2:0] pin_w = {one_pulse_line_i, zero_pulse_line_i, power_down_request_n_i};
	logic [2:0] pin_f_w;

	for (genvar i = 0; i < 3; i++) begin : g_sync
		localparam logic RST_V = (i == 0);
		logic [2:0] sh_r;
		logic       f_r;
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				sh_r <= {3{RST_V}};
				f_r  <= RST_V;
			end else begin
				sh_r <= {sh_r[1:0], pin_w[i]};
				if (sh_r[1] == sh_r[2]) begin
					f_r <= sh_r[2];
				end
			end
		end
		assign pin_f_w[i] = f_r;
	end

	// Undriven pin floats high through the pad pull-up, so high means run
	wire pd_act_w = !pin_f_w[0];

	// ----------------------------------------
	// Control state
	// ----------------------------------------
	tfd_state_e              state_r;
	tfd_state_e              state_nxt;
	logic [CNT_W-1:0]        cnt_r;
	logic [3:0]              ones_r;
	logic [5:0]              body_cnt_r;
	logic [BODY_BITS-1:0]    body_r;

	wire bit_w      = bits.bit_valid;
	wire restart_hit_w = cnt_r == CNT_W'(RESTART_CYC_P - 1);
	wire shut_hit_w    = cnt_r == CNT_W'(SHUTDOWN_CYC_P - 1);
	wire sync_hit_w = bit_w && bits.bit_value && ones_r == 4'(SYNC_ONES - 1);
	wire body_end_w = bit_w && body_cnt_r == 6'(BODY_BITS - 1);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_WAKE: begin
				if (pd_act_w) state_nxt = ST_SHUT;
				else if (restart_hit_w) state_nxt = ST_HUNT;
			end
			ST_HUNT: begin
				if (pd_act_w) state_nxt = ST_SHUT;
				else if (sync_hit_w) state_nxt = ST_COLLECT;
			end
			ST_COLLECT: begin
				if (pd_act_w) state_nxt = ST_SHUT;
				else if (body_end_w) state_nxt = ST_HUNT;
			end
			ST_SHUT: begin
				if (!pd_act_w) state_nxt = ST_WAKE;
				else if (shut_hit_w) state_nxt = ST_DOWN;
			end
			ST_DOWN: begin
				if (!pd_act_w) state_nxt = ST_WAKE;
			end
		endcase
	end

	wire run_w = state_r == ST_HUNT || state_r == ST_COLLECT;

	// Decoder is held clear outside the run states so a release starts afresh
	assign bits.restart = !run_w || pd_act_w;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ST_WAKE;
			cnt_r   <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= (state_nxt != state_r) ? '0 : cnt_r + CNT_W'(1);
		end
	end

	// ----------------------------------------
	// Sync hunt and body capture
	// ----------------------------------------
	wire [BODY_BITS-1:0] body_nxt_w = {body_r[BODY_BITS-2:0], bits.bit_value};

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ones_r     <= 4'h0;
			body_cnt_r <= 6'h00;
			body_r     <= '0;
		end else if (state_r != ST_HUNT) begin
			ones_r <= 4'h0;
			if (state_r != ST_COLLECT) begin
				body_cnt_r <= 6'h00;
			end else if (bit_w) begin
				body_r     <= body_nxt_w;
				body_cnt_r <= body_end_w ? 6'h00 : body_cnt_r + 6'h01;
			end
		end else if (bit_w) begin
			ones_r <= bits.bit_value ? ones_r + 4'h1 : 4'h0;
		end
	end

	// ----------------------------------------
	// Frame checks
	// ----------------------------------------
	logic [ID_BITS-1:0]  id_w;
	logic [ROWS-1:0]     row_ok_w;
	logic [COL_BITS-1:0] col_xor_w;

	for (genvar r = 0; r < ROWS; r++) begin : g_row
		localparam int unsigned TOP = BODY_BITS - 1 - r * ROW_BITS;
		wire [NIB_BITS-1:0] nib_w = body_nxt_w[TOP -: NIB_BITS];
		assign id_w[ID_BITS - 1 - r * NIB_BITS -: NIB_BITS] = nib_w;
		assign row_ok_w[r] = (^nib_w) == body_nxt_w[TOP - NIB_BITS];
	end

	// Only payload nibbles enter the column sums
	always_comb begin
		col_xor_w = '0;
		for (int r = 0; r < ROWS; r++) begin
			col_xor_w = col_xor_w ^ id_w[ID_BITS - 1 - r * NIB_BITS -: NIB_BITS];
		end
	end

	wire col_ok_w   = body_nxt_w[COL_BITS:1] == col_xor_w;
	wire stop_ok_w  = body_nxt_w[0] == STOP_VAL;
	wire done_w     = state_r == ST_COLLECT && body_end_w && !pd_act_w;
	wire good_w     = done_w && (&row_ok_w) && col_ok_w && stop_ok_w;

	logic [ID_BITS-1:0]     id_r;
	logic [VENDOR_BITS-1:0] vendor_r;
	logic                   valid_r;
	logic                   err_r;
	logic                   ready_r;
	logic                   down_r;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			id_r     <= '0;
			vendor_r <= '0;
			valid_r  <= 1'b0;
			err_r    <= 1'b0;
			ready_r  <= 1'b0;
			down_r   <= 1'b0;
		end else begin
			valid_r <= good_w;
			err_r   <= done_w && !good_w;
			if (good_w) begin
				id_r     <= id_w;
				vendor_r <= id_w[ID_BITS-1 -: VENDOR_BITS];
			end
			ready_r <= state_nxt == ST_HUNT || state_nxt == ST_COLLECT;
			down_r  <= state_nxt == ST_DOWN;
		end
	end

	// ----------------------------------------
	// Pull-up sense at power-up
	// ----------------------------------------
	logic [4:0] sense_cnt_r;
	logic       sensed_r;
	logic       pulse_en_r;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sense_cnt_r <= 5'h00;
			sensed_r    <= 1'b0;
			pulse_en_r  <= 1'b0;
		end else if (!sensed_r) begin
			sense_cnt_r <= sense_cnt_r + 5'h01;
			if (sense_cnt_r == 5'(SENSE_CYC - 1)) begin
				sensed_r   <= 1'b1;
				pulse_en_r <= pin_f_w[1] && pin_f_w[2];
			end
		end
	end

	// ----------------------------------------
	// Serial transmitter
	// ----------------------------------------
	// Frames that arrive while a transfer is running are not queued
	logic                 tx_busy_r;
	logic [ID_BITS-1:0]   tx_data_r;
	logic [2:0]           tx_byte_r;
	logic [3:0]           tx_bit_r;
	logic [CNT_W-1:0]     tx_cnt_r;
	logic                 tx_r;

	wire [BYTE_BITS-1:0] tx_cur_w  = tx_data_r[ID_BITS-1 -: BYTE_BITS];
	wire                 tx_tick_w = tx_cnt_r == CNT_W'(BAUD_CYC_P - 1);
	wire                 tx_last_w = tx_bit_r == 4'(UART_LAST_BIT);
	wire                 tx_lvl_w  = tx_bit_r == 4'h0 ? UART_START :
		tx_last_w ? UART_IDLE : tx_cur_w[3'(tx_bit_r - 4'h1)];

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_busy_r <= 1'b0;
			tx_data_r <= '0;
			tx_byte_r <= 3'h0;
			tx_bit_r  <= 4'h0;
			tx_cnt_r  <= '0;
			tx_r      <= UART_IDLE;
		end else if (!run_w) begin
			tx_busy_r <= 1'b0;
			tx_r      <= UART_IDLE;
		end else if (!tx_busy_r) begin
			tx_r <= UART_IDLE;
			if (good_w) begin
				tx_busy_r <= 1'b1;
				tx_data_r <= id_w;
				tx_byte_r <= 3'h0;
				tx_bit_r  <= 4'h0;
				tx_cnt_r  <= '0;
			end
		end else begin
			tx_r     <= tx_lvl_w;
			tx_cnt_r <= tx_tick_w ? '0 : tx_cnt_r + CNT_W'(1);
			if (tx_tick_w) begin
				tx_bit_r <= tx_last_w ? 4'h0 : tx_bit_r + 4'h1;
				if (tx_last_w) begin
					tx_data_r <= {tx_data_r[ID_BITS-BYTE_BITS-1:0], {BYTE_BITS{1'b0}}};
					tx_byte_r <= tx_byte_r + 3'h1;
					tx_busy_r <= tx_byte_r != 3'(ID_BYTES - 1);
				end
			end
		end
	end

	// ----------------------------------------
	// Pulse output
	// ----------------------------------------
	logic                 pl_busy_r;
	logic                 pl_on_r;
	logic [ID_BITS-1:0]   pl_data_r;
	logic [5:0]           pl_bits_r;
	logic [CNT_W-1:0]     pl_cnt_r;
	logic                 z_oe_r;
	logic                 o_oe_r;
	logic                 line_lvl_r;

	wire pl_on_end_w  = pl_cnt_r == CNT_W'(PULSE_CYC_P - 1);
	wire pl_gap_end_w = pl_cnt_r == CNT_W'(PULSE_GAP_CYC_P - 1);

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pl_busy_r <= 1'b0;
			pl_on_r   <= 1'b0;
			pl_data_r <= '0;
			pl_bits_r <= 6'h00;
			pl_cnt_r  <= '0;
		end else if (!run_w || !pulse_en_r) begin
			pl_busy_r <= 1'b0;
			pl_on_r   <= 1'b0;
		end else if (!pl_busy_r) begin
			if (good_w) begin
				pl_busy_r <= 1'b1;
				pl_on_r   <= 1'b1;
				pl_data_r <= id_w;
				pl_bits_r <= 6'h00;
				pl_cnt_r  <= '0;
			end
		end else if (pl_on_r) begin
			pl_cnt_r <= pl_on_end_w ? '0 : pl_cnt_r + CNT_W'(1);
			pl_on_r  <= !pl_on_end_w;
		end else begin
			pl_cnt_r <= pl_gap_end_w ? '0 : pl_cnt_r + CNT_W'(1);
			if (pl_gap_end_w) begin
				pl_data_r <= {pl_data_r[ID_BITS-2:0], 1'b0};
				pl_bits_r <= pl_bits_r + 6'h01;
				pl_busy_r <= pl_bits_r != 6'(ID_BITS - 1);
				pl_on_r   <= pl_bits_r != 6'(ID_BITS - 1);
			end
		end
	end

	// Lines are only ever pulled low; the pull-up outside makes the high
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			z_oe_r     <= 1'b0;
			o_oe_r     <= 1'b0;
			line_lvl_r <= 1'b0;
		end else begin
			z_oe_r     <= pl_busy_r && pl_on_r && !pl_data_r[ID_BITS-1];
			o_oe_r     <= pl_busy_r && pl_on_r && pl_data_r[ID_BITS-1];
			line_lvl_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign zero_pulse_line_o    = line_lvl_r;
	assign zero_pulse_line_oe_o = z_oe_r;
	assign one_pulse_line_o     = line_lvl_r;
	assign one_pulse_line_oe_o  = o_oe_r;
	assign uart_tx_o            = tx_r;
	assign id_o                 = id_r;
	assign vendor_id_o          = vendor_r;
	assign id_valid_o           = valid_r;
	assign frame_error_o        = err_r;
	assign ready_o              = ready_r;
	assign powered_down_o       = down_r;
	assign pulse_out_enabled_o  = pulse_en_r;

endmodule

// ==== tb/tfd_tag_model.sv ====
// Transponder model: sends Manchester coded frames on the demodulated line.
// Assumes the caller hands over a full 64-bit frame, first bit at bit 63.
module tfd_tag_model
	import tfd_pkg::*;
#(
	parameter int unsigned BIT_CYC_P = BIT_CYC
) (
	input  wire logic core_clk_i,
	output logic      line_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial line_o = 1'h1;

	// ----------------------------------------
	// Half-bit and frame drivers
	// ----------------------------------------
	task automatic half(input logic v);
		line_o <= v;
		repeat (BIT_CYC_P / 2) @(posedge core_clk_i);
	endtask

	// Idle high before the lead bit, so the first edge is a true mid-bit edge
	task automatic send(input logic [63:0] f);
		@(posedge core_clk_i);
		half(1'h1);
		half(1'h0);
		for (int i = 63; i >= 0; i--) begin
			half(~f[i]);
			half(f[i]);
		end
		repeat (5) half(1'h1);
	endtask
endmodule

// ==== tb/tfd_frame_decoder_chk.sv ====
// Port checker for the tag frame decoder, bound to its top module.
// Assumes one core clock and an async active-high reset.
module tfd_frame_decoder_chk
	import tfd_pkg::*;
#(
	parameter int unsigned SHUTDOWN_CYC_P = SHUTDOWN_CYC,
	parameter int unsigned RESTART_CYC_P  = RESTART_CYC
) (
	input wire logic                   core_clk_i,
	input wire logic                   rst_i,
	input wire logic                   power_down_request_n_i,
	input wire logic                   zero_pulse_line_o,
	input wire logic                   zero_pulse_line_oe_o,
	input wire logic                   one_pulse_line_o,
	input wire logic                   one_pulse_line_oe_o,
	input wire logic [ID_BITS-1:0]     id_o,
	input wire logic [VENDOR_BITS-1:0] vendor_id_o,
	input wire logic                   id_valid_o,
	input wire logic                   frame_error_o,
	input wire logic                   ready_o,
	input wire logic                   powered_down_o,
	input wire logic                   pulse_out_enabled_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Pin level duration counters
	// ----------------------------------------
	// Margins cover the pin filter and output register lag
	localparam int SHUT_LIM = SHUTDOWN_CYC_P + 8;
	localparam int REST_LIM = RESTART_CYC_P + 10;
	int lo_cnt_r;
	int hi_cnt_r;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lo_cnt_r <= 0;
			hi_cnt_r <= 0;
		end else begin
			// Saturate at the limit so the check stays live at full-size counts
			lo_cnt_r <= power_down_request_n_i ? 0 : (lo_cnt_r < SHUT_LIM ? lo_cnt_r + 1 : lo_cnt_r);
			hi_cnt_r <= !power_down_request_n_i ? 0 : (hi_cnt_r < REST_LIM ? hi_cnt_r + 1 : hi_cnt_r);
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_req_fall;
		$fell(power_down_request_n_i);
	endsequence
	sequence s_good;
		id_valid_o;
	endsequence

	a_valid_one_cycle: assert property (s_good |=> !id_valid_o) else $error("id valid too long");
	a_valid_err_excl: assert property (!(id_valid_o && frame_error_o)) else $error("good and bad at once");
	a_vendor_top_byte: assert property (vendor_id_o == id_o[39:32]) else $error("vendor byte mismatch");
	a_id_hold: assert property (!id_valid_o |-> $stable(id_o)) else $error("id changed without valid");
	a_line_pull_low: assert property ((zero_pulse_line_oe_o |-> !zero_pulse_line_o)
		and (one_pulse_line_oe_o |-> !one_pulse_line_o)) else $error("pulse line driven high");
	a_no_pulse_off: assert property (!pulse_out_enabled_o |-> !zero_pulse_line_oe_o && !one_pulse_line_oe_o)
		else $error("pulse while disabled");
	a_lines_exclusive: assert property (!(zero_pulse_line_oe_o && one_pulse_line_oe_o))
		else $error("both pulse lines active");
	a_ready_drops: assert property (s_req_fall |-> ##[1:8] !ready_o) else $error("ready kept on request");
	a_shut_done: assert property (lo_cnt_r == SHUT_LIM |-> powered_down_o && !ready_o)
		else $error("shutdown too slow");
	a_restart_ready: assert property (hi_cnt_r == REST_LIM |-> ready_o) else $error("restart too slow");
	a_down_quiet: assert property (powered_down_o |-> !ready_o && !id_valid_o) else $error("active while down");

	c_good: cover property (s_good);
	c_bad: cover property (frame_error_o);
endmodule

bind tfd_frame_decoder tfd_frame_decoder_chk #(
	.SHUTDOWN_CYC_P(SHUTDOWN_CYC_P),
	.RESTART_CYC_P (RESTART_CYC_P)
) u_chk (
	.core_clk_i, .rst_i, .power_down_request_n_i, .zero_pulse_line_o, .zero_pulse_line_oe_o,
	.one_pulse_line_o, .one_pulse_line_oe_o, .id_o, .vendor_id_o, .id_valid_o, .frame_error_o,
	.ready_o, .powered_down_o, .pulse_out_enabled_o
);

// ==== tb/tag_frame_decoder_test.sv ====
// Self-checking bench for the tag frame decoder with a transponder model.
// Assumes shortened counts; pad pull-ups modelled on the shutdown and pulse pins.
module tag_frame_decoder_test
	import tfd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Set-up
	// ----------------------------------------
	localparam int unsigned BIT_C  = 64;
	localparam int unsigned SHUT_C = 20;
	localparam int unsigned REST_C = 30;
	localparam int unsigned BAUD_C = 8;
	localparam int unsigned PUL_C  = 4;
	localparam int unsigned GAP_C  = 8;

	logic                   core_clk_i = 1'h0;
	logic                   rst_i      = 1'h1;
	logic                   pd_drv     = 1'h0;
	logic                   pd_val     = 1'h1;
	logic                   pu         = 1'h1;
	tri1                    power_down_request_n_i;
	wire                    rx_demod_i;
	wire                    zero_pulse_line_i;
	wire                    one_pulse_line_i;
	logic                   zero_pulse_line_o;
	logic                   zero_pulse_line_oe_o;
	logic                   one_pulse_line_o;
	logic                   one_pulse_line_oe_o;
	logic                   uart_tx_o;
	logic [ID_BITS-1:0]     id_o;
	logic [VENDOR_BITS-1:0] vendor_id_o;
	logic                   id_valid_o;
	logic                   frame_error_o;
	logic                   ready_o;
	logic                   powered_down_o;
	logic                   pulse_out_enabled_o;
	int                     errors = 0;
	int                     samples_checked = 0;
	int                     nv = 0;
	int                     ne = 0;

	always #20 core_clk_i = ~core_clk_i;
	assign power_down_request_n_i = pd_drv ? pd_val : 1'hz;
	assign zero_pulse_line_i = zero_pulse_line_oe_o ? zero_pulse_line_o : pu;
	assign one_pulse_line_i = one_pulse_line_oe_o ? one_pulse_line_o : pu;

	tfd_tag_model #(.BIT_CYC_P(BIT_C)) tag (.core_clk_i(core_clk_i), .line_o(rx_demod_i));

	tfd_frame_decoder #(
		.BIT_CYC_P(BIT_C), .SHUTDOWN_CYC_P(SHUT_C), .RESTART_CYC_P(REST_C),
		.BAUD_CYC_P(BAUD_C), .PULSE_CYC_P(PUL_C), .PULSE_GAP_CYC_P(GAP_C)
	) DUT (
		.core_clk_i, .rst_i, .rx_demod_i, .power_down_request_n_i, .zero_pulse_line_i, .zero_pulse_line_o,
		.zero_pulse_line_oe_o, .one_pulse_line_i, .one_pulse_line_o, .one_pulse_line_oe_o, .uart_tx_o,
		.id_o, .vendor_id_o, .id_valid_o, .frame_error_o, .ready_o, .powered_down_o, .pulse_out_enabled_o
	);

	always @(posedge core_clk_i) begin
		if (rst_i === 1'h0) begin
			nv <= nv + (id_valid_o === 1'h1);
			ne <= ne + (frame_error_o === 1'h1);
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	function automatic logic [63:0] mk(input logic [39:0] id);
		logic [63:0] f;
		logic [3:0]  n;
		logic [3:0]  c;
		c = 4'h0;
		f[63:55] = 9'h1FF;
		for (int r = 0; r < 10; r++) begin
			n = id[39-4*r -: 4];
			f[54-5*r -: 5] = {n, ^n};
			c = c ^ n;
		end
		f[4:0] = {c, STOP_VAL};
		return f;
	endfunction

	task automatic wait_ready(input int lim);
		for (int i = 0; i < lim && ready_o !== 1'h1; i++) @(negedge core_clk_i);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset(input logic pull);
		@(posedge core_clk_i);
		pu <= pull;
		rst_i <= 1'h1;
		repeat (20) @(posedge core_clk_i);
		chk("tx_idle", uart_tx_o, 40'h1);
		chk("ready_in_rst", ready_o, 40'h0);
		rst_i <= 1'h0;
		wait_ready(REST_C + 20);
		chk("ready", ready_o, 40'h1);
		chk("pulse_en", pulse_out_enabled_o, pull);
		$display("test reset done");
	endtask

	task automatic t_good(input logic [39:0] id, input logic en);
		fork
			tag.send(mk(id));
			begin
				for (int i = 0; i < BIT_C * 70 && id_valid_o !== 1'h1; i++) @(negedge core_clk_i);
				chk("id", id_o, id);
				chk("vendor", vendor_id_o, id[39:32]);
				fork
					begin
						repeat (6) @(negedge core_clk_i);
						chk("tx_start", uart_tx_o, 40'h0);
						for (int j = 0; j < 9; j++) begin
							repeat (BAUD_C) @(negedge core_clk_i);
							chk("tx_bit", uart_tx_o, j < 8 ? id[32+j] : 1'h1);
						end
					end
					begin
						for (int j = 0; j < 3; j++) begin
							repeat (j == 0 ? 3 : PUL_C + GAP_C) @(negedge core_clk_i);
							chk("zero_line", zero_pulse_line_oe_o, en & ~id[39-j]);
							chk("one_line", one_pulse_line_oe_o, en & id[39-j]);
						end
					end
				join
			end
		join
		$display("test good frame done");
	endtask

	task automatic t_bad();
		int             ks[4] = '{50, 4, 0, 54};
		logic [39:0]    old;
		int             nv0;
		int             ne0;
		foreach (ks[k]) begin
			old = id_o;
			nv0 = nv;
			ne0 = ne;
			tag.send(mk(40'hA50F3C96E1) ^ (64'h1 << ks[k]));
			chk("err_count", ne - ne0, 40'h1);
			chk("no_valid", nv - nv0, 40'h0);
			chk("id_kept", id_o, old);
		end
		$display("test bad frames done");
	endtask

	task automatic t_pd();
		int nv0;
		@(posedge core_clk_i);
		pd_drv <= 1'h1;
		pd_val <= 1'h0;
		for (int i = 0; i < 10 && ready_o !== 1'h0; i++) @(negedge core_clk_i);
		chk("ready_off", ready_o, 40'h0);
		repeat (SHUT_C + 10) @(negedge core_clk_i);
		chk("down", powered_down_o, 40'h1);
		nv0 = nv;
		tag.send(mk(40'h1122334455));
		chk("down_ignored", nv - nv0, 40'h0);
		@(posedge core_clk_i);
		pd_drv <= 1'h0;
		repeat (8) @(negedge core_clk_i);
		chk("reinit", ready_o, 40'h0);
		wait_ready(REST_C + 20);
		chk("ready_again", ready_o, 40'h1);
		chk("up", powered_down_o, 40'h0);
		$display("test power down done");
	endtask

	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	initial begin
		t_reset(1'h1);
		t_good(40'h3C1234ABCD, 1'h1);
		t_bad();
		t_pd();
		t_good(40'hF08E2D7B19, 1'h1);
		t_reset(1'h0);
		t_good(40'h5A6987C3E4, 1'h0);
		end_sim();
	end

	// Run is about 35000 cycles; limit leaves room
	initial begin
		repeat (70000) @(posedge core_clk_i);
		errors++;
		end_sim();
	end
endmodule
